// ### core/pidsl_consts.svh
/*
  timing, reset and offset constants for the pid setpoint loop.
  assumes inclusion by bare name; definitions only.
*/
`ifndef PIDSL_CONSTS_SVH
`define PIDSL_CONSTS_SVH
`define PIDSL_CLK_HZ 20000000
`define PIDSL_SAMPLE_US 1000
`define PIDSL_SAMPLE_CYC ((`PIDSL_CLK_HZ / 1000000) * `PIDSL_SAMPLE_US)
`define PIDSL_FREQ_MAX 16'h4650
`define PIDSL_PID_MODE_CODE 8'h09
// contact assignment codes are arbitrary; 66 stays unused since it forbids closing any contact in pid mode
`define PIDSL_CANCEL_CODE 8'h44
`define PIDSL_IRESET_CODE 8'h43
`define PIDSL_ADDR_PRESET1 8'h00
`define PIDSL_ADDR_PRESET2 8'h04
`define PIDSL_ADDR_PRESET3 8'h08
`define PIDSL_ADDR_PRESET4 8'h0C
`define PIDSL_ADDR_JOG 8'h10
`define PIDSL_ADDR_FBGAIN 8'h14
`define PIDSL_ADDR_PGAIN 8'h18
`define PIDSL_ADDR_ITIME 8'h1C
`define PIDSL_ADDR_DTIME 8'h20
`define PIDSL_ADDR_IUPPER 8'h24
`define PIDSL_ADDR_LAG 8'h28
`define PIDSL_ADDR_MODE 8'h2C
`define PIDSL_ADDR_REFSRC 8'h30
`define PIDSL_ADDR_MFASSIGN 8'h34
`define PIDSL_ADDR_STATUS 8'h38
`define PIDSL_ADDR_OUTPUT 8'h3C
`define PIDSL_RST_PRESET1 16'h1770
`define PIDSL_RST_JOG 16'h0258
`define PIDSL_RST_FBGAIN 16'h0064
`define PIDSL_RST_PGAIN 16'h000A
`define PIDSL_RST_ITIME 16'h0064
`define PIDSL_RST_IUPPER 16'h0064
`define PIDSL_FB_FULL 16'h0FFF
`define PIDSL_CUR_ZERO 16'h0333
`define PIDSL_CUR_SPAN 16'h0CCC
`endif

// ### core/pidsl_pkg.sv
/*
  types for the pid setpoint loop.
  assumes nothing beyond the header of constants.
*/
package pidsl_pkg;
  typedef enum logic [1:0] {PIDSL_IDLE, PIDSL_CALC, PIDSL_INTEG, PIDSL_FILT} pidsl_state_t;
endpackage

// ### core/pidsl_cfg_if.sv
/*
  interface carrying loop settings from the register file to the loop.
  assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface pidsl_cfg_if;
  logic [15:0] preset [0:4];
  logic [15:0] fb_gain;
  logic [15:0] p_gain;
  logic [15:0] i_time;
  logic [15:0] d_time;
  logic [15:0] i_upper;
  logic [15:0] lag_tc;
  logic loop_on;
  logic aux_ref;
  logic cancel_pin;
  logic ireset_pin;
  modport regs (output preset, fb_gain, p_gain, i_time, d_time, i_upper, lag_tc, loop_on, aux_ref,
                cancel_pin, ireset_pin);
  modport loop (input preset, fb_gain, p_gain, i_time, d_time, i_upper, lag_tc, loop_on, aux_ref,
                cancel_pin, ireset_pin);
endinterface
`default_nettype wire

// ### core/pidsl_regs.sv
/*
  classic wishbone register file: settings and contact assignments.
  assumes a single-cycle master; ack comes one cycle after stb.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pidsl_consts.svh"
module pidsl_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [3:0] mf_in,
  input wire logic [31:0] status_word,
  input wire logic [15:0] out_word,
  output logic [31:0] rd_data,
  pidsl_cfg_if.regs cfg
);
  logic [15:0] reg_ff [0:11];
  logic [7:0] mf_assign_ff [0:3];
  logic wr_go;
  logic [31:0] rd_mux;
  logic [3:0] cancel_hit;
  logic [3:0] ireset_hit;

  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i;

  // settings sit at word index 0..11; 16-bit data in the low lanes
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1) begin : g_reg
      localparam logic [15:0] RST_VAL = (gi == 0) ? `PIDSL_RST_PRESET1 : (gi == 4) ? `PIDSL_RST_JOG :
        (gi == 5) ? `PIDSL_RST_FBGAIN : (gi == 6) ? `PIDSL_RST_PGAIN : (gi == 7) ? `PIDSL_RST_ITIME :
        (gi == 9) ? `PIDSL_RST_IUPPER : 16'h0000;
      wire hit = wr_go & (wb_adr_i == 8'(gi * 4));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          reg_ff[gi] <= RST_VAL;
        end else if (hit) begin
          if (wb_sel_i[0]) reg_ff[gi][7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) reg_ff[gi][15:8] <= wb_dat_i[15:8];
        end
      end
    end
    // one byte per contact terminal assignment
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mf
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mf_assign_ff[gi] <= 8'h00;
        end else if (wr_go & (wb_adr_i == `PIDSL_ADDR_MFASSIGN) & wb_sel_i[gi]) begin
          mf_assign_ff[gi] <= wb_dat_i[gi*8 +: 8];
        end
      end
      assign cancel_hit[gi] = mf_in[gi] & (mf_assign_ff[gi] == `PIDSL_CANCEL_CODE);
      assign ireset_hit[gi] = mf_in[gi] & (mf_assign_ff[gi] == `PIDSL_IRESET_CODE);
    end
  endgenerate

  assign cfg.preset[0] = reg_ff[0];
  assign cfg.preset[1] = reg_ff[1];
  assign cfg.preset[2] = reg_ff[2];
  assign cfg.preset[3] = reg_ff[3];
  assign cfg.preset[4] = reg_ff[4];
  assign cfg.fb_gain = reg_ff[5];
  assign cfg.p_gain = reg_ff[6];
  assign cfg.i_time = reg_ff[7];
  assign cfg.d_time = reg_ff[8];
  assign cfg.i_upper = reg_ff[9];
  assign cfg.lag_tc = reg_ff[10];
  assign cfg.loop_on = (reg_ff[11][7:0] == `PIDSL_PID_MODE_CODE);
  assign cfg.aux_ref = (reg_ff[11][11:8] == 4'h0);
  assign cfg.cancel_pin = |cancel_hit;
  assign cfg.ireset_pin = |ireset_hit;

  // read mux; unmapped words read zero
  assign rd_mux = (wb_adr_i <= 8'h2C && wb_adr_i[1:0] == 2'b00) ? {16'h0000, reg_ff[wb_adr_i[5:2]]} :
    (wb_adr_i == `PIDSL_ADDR_MFASSIGN) ? {mf_assign_ff[3], mf_assign_ff[2], mf_assign_ff[1], mf_assign_ff[0]} :
    (wb_adr_i == `PIDSL_ADDR_STATUS) ? status_word :
    (wb_adr_i == `PIDSL_ADDR_OUTPUT) ? {16'h0000, out_word} : 32'h0000_0000;
  assign rd_data = rd_mux;
endmodule
`default_nettype wire

// ### core/pidsl_filter.sv
/*
  first-order lag on the loop output, stepped once per sample.
  assumes step pulses at the loop sample rate.
*/
`timescale 1ns/1ns
`default_nettype none
module pidsl_filter #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic step,
  input wire logic [W-1:0] din,
  input wire logic [15:0] tc,
  output logic [W-1:0] dout
);
  logic [W+15:0] acc_ff;
  logic signed [W+16:0] diff;
  logic signed [W+16:0] incr;
  logic [31:0] denom;

  // tc in 0.1 s, sample 1 ms: alpha = 1/(tc*100+1); zero tc passes through
  assign denom = 32'(tc) * 32'd100 + 32'd1;
  assign diff = $signed({1'b0, din, 16'h0000}) - $signed({1'b0, acc_ff});
  assign incr = diff / $signed({1'b0, denom[W+15:0]});

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (step) begin
      acc_ff <= (tc == 16'h0000) ? {din, 16'h0000} : (W+16)'(acc_ff + incr[W+15:0]);
    end
  end
  assign dout = acc_ff[W+15:16];
endmodule
`default_nettype wire

// ### core/pidsl_top.sv
/*
  pid setpoint loop: target selection, feedback scaling, pid, clamp, lag.
  assumes feedback inputs are 12-bit adc words from another domain, contacts are raw pins,
  and software programs settings over classic wishbone.
*/
// Our own choices: the Wishbone slave port and the register addresses.
// Function
// - loop runs only when mode select holds code 09
// - jog picks fifth preset; else step2/step1 pick presets one to four
// - reference digit 0 uses aux input for preset one, 1 uses preset
// - feedback from 0-10 V input or 4-20 mA input
// - presets span 0 to 180.00 Hz in 0.01 Hz; defaults 60, 6, 0
// - feedback scaled by detect gain 0.01-10.00, default 1.00
// - proportional term is gain 0.0-10.0 times deviation, default 1.0
// - integral time 0-100 s, default 10 s; shorter means stronger
// - derivative time 0-1 s, default 0; zero removes derivative
// - integral clamped to upper bound 0-109 percent, default 100
// - output passes a lag 0-2.5 s; zero means unfiltered
// - integral-reset contact clears accumulated integral
// - pid-cancel contact makes target the frequency command
// - output is sum of p, i and d contributions
`timescale 1ns/1ns
`default_nettype none
`include "pidsl_consts.svh"
module pidsl_top #(
  parameter int SAMPLE_CYC = `PIDSL_SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic jog_in,
  input wire logic step1_in,
  input wire logic step2_in,
  input wire logic [3:0] mf_in,
  input wire logic fb_current_sel,
  input wire logic [11:0] voltage_sensor_input,
  input wire logic [11:0] current_sensor_input,
  input wire logic [11:0] aux_input,
  output logic [15:0] freq_cmd,
  output logic loop_active
);
  pidsl_cfg_if cfg ();

  // two-stage synchronisers for every pin input
  logic [43:0] pin_s1_ff;
  logic [43:0] pin_s2_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {jog_in, step1_in, step2_in, mf_in, fb_current_sel, voltage_sensor_input,
                    current_sensor_input, aux_input};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire jog_s = pin_s2_ff[43];
  wire step1_s = pin_s2_ff[42];
  wire step2_s = pin_s2_ff[41];
  wire [3:0] mf_s = pin_s2_ff[40:37];
  wire cur_sel_s = pin_s2_ff[36];
  wire [11:0] vin_s = pin_s2_ff[35:24];
  wire [11:0] ain_s = pin_s2_ff[23:12];
  wire [11:0] aux_s = pin_s2_ff[11:0];

  logic [31:0] rd_data;
  logic [31:0] status_w;
  logic [15:0] filt_out;

  pidsl_regs i_pidsl_regs (
    .clk(clk),
    .rst(rst),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .mf_in(mf_s),
    .status_word(status_w),
    .out_word(freq_cmd),
    .rd_data(rd_data),
    .cfg(cfg)
  );

  // ack one cycle after request, dropped the next cycle
  logic ack_ff;
  logic [31:0] dat_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      // capture only on a taken request, so read data stands while the bus is idle
      if (wb_cyc_i & wb_stb_i & ~ack_ff) dat_ff <= rd_data;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // aux input 0..4095 maps onto 0..180.00 Hz
  wire [15:0] aux_hz = 16'((32'(aux_s) * 32'(`PIDSL_FREQ_MAX)) / 32'(`PIDSL_FB_FULL));
  wire [2:0] sel_idx = jog_s ? 3'd4 : {1'b0, step2_s, step1_s};
  wire [15:0] preset_raw = cfg.preset[sel_idx];
  wire [15:0] preset_lim = (preset_raw > `PIDSL_FREQ_MAX) ? `PIDSL_FREQ_MAX : preset_raw;
  wire [15:0] target = (sel_idx == 3'd0 && cfg.aux_ref) ? aux_hz : preset_lim;

  // current path: 4 mA sits at one fifth of full scale; below it reads zero
  wire [11:0] ain_off = (ain_s > 12'(`PIDSL_CUR_ZERO)) ? 12'(ain_s - 12'(`PIDSL_CUR_ZERO)) : 12'h000;
  wire [15:0] fb_raw_hz = cur_sel_s ?
    16'((32'(ain_off) * 32'(`PIDSL_FREQ_MAX)) / 32'(`PIDSL_CUR_SPAN)) :
    16'((32'(vin_s) * 32'(`PIDSL_FREQ_MAX)) / 32'(`PIDSL_FB_FULL));
  wire [15:0] gain_clip = (cfg.fb_gain == 16'h0000) ? 16'h0001 : (cfg.fb_gain > 16'h03E8) ? 16'h03E8 : cfg.fb_gain;
  wire [31:0] fb_scaled = (32'(fb_raw_hz) * 32'(gain_clip)) / 32'd100;

  // sample tick from a free counter
  logic [31:0] tick_cnt_ff;
  wire tick = (tick_cnt_ff == 32'(SAMPLE_CYC - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else begin
      tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
    end
  end

  // deviation in 0.01 Hz, signed 40-bit; terms, integrator and sum signed 48-bit to leave headroom
  logic signed [39:0] dev_ff;
  logic signed [39:0] prev_dev_ff;
  logic signed [47:0] integ_ff;
  logic signed [47:0] pid_ff;
  logic [15:0] pid_out_ff;
  logic filt_step_ff;
  pidsl_pkg::pidsl_state_t state_ff;
  pidsl_pkg::pidsl_state_t nxt_state;

  wire signed [39:0] nxt_dev = $signed({24'h000000, target}) - $signed({8'h00, fb_scaled});
  wire [15:0] p_lim = (cfg.p_gain > 16'h0064) ? 16'h0064 : cfg.p_gain;
  wire signed [47:0] p_term = (48'(dev_ff) * $signed({32'h0, p_lim})) / 48'sd10;
  wire [15:0] it_lim = (cfg.i_time > 16'h03E8) ? 16'h03E8 : cfg.i_time;
  // per-sample increment dev*T/Ti with T 1 ms, Ti in 0.1 s; Ti zero adds nothing, so the integrator holds its value
  wire signed [47:0] i_step = (it_lim == 16'h0000) ? 48'sd0 :
    (48'(dev_ff) * 48'sd1000) / ($signed({32'h0, it_lim}) * 48'sd100);
  wire [15:0] dt_lim = (cfg.d_time > 16'h0064) ? 16'h0064 : cfg.d_time;
  // d term is Td/T times change in deviation; Td in 0.01 s
  wire signed [47:0] d_term = (48'(dev_ff - prev_dev_ff) * $signed({32'h0, dt_lim}) * 48'sd10);
  wire [15:0] iu_lim = (cfg.i_upper > 16'h006D) ? 16'h006D : cfg.i_upper;
  // bound in percent of 180 Hz, kept in the integrator's own scale of 0.01 Hz * 1000
  wire signed [47:0] i_bound = (48'(iu_lim) * 48'(`PIDSL_FREQ_MAX) * 48'sd1000) / 48'sd100;
  wire signed [47:0] integ_sum = integ_ff + i_step;
  wire signed [47:0] integ_clip = (integ_sum > i_bound) ? i_bound :
    (integ_sum < -i_bound) ? -i_bound : integ_sum;
  wire signed [47:0] pid_sum = p_term + integ_ff / 48'sd1000 + d_term;
  wire [15:0] pid_sat = (pid_ff < 48'sd0) ? 16'h0000 :
    (pid_ff > 48'(`PIDSL_FREQ_MAX)) ? `PIDSL_FREQ_MAX : pid_ff[15:0];

  // sequence per tick: latch deviation, integrate, sum, then filter step
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pidsl_pkg::PIDSL_IDLE: if (tick) nxt_state = pidsl_pkg::PIDSL_CALC;
      pidsl_pkg::PIDSL_CALC: nxt_state = pidsl_pkg::PIDSL_INTEG;
      pidsl_pkg::PIDSL_INTEG: nxt_state = pidsl_pkg::PIDSL_FILT;
      pidsl_pkg::PIDSL_FILT: nxt_state = pidsl_pkg::PIDSL_IDLE;
      default: nxt_state = pidsl_pkg::PIDSL_IDLE;
    endcase
  end

  wire run_loop = cfg.loop_on & ~cfg.cancel_pin;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= pidsl_pkg::PIDSL_IDLE;
      dev_ff <= '0;
      prev_dev_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == pidsl_pkg::PIDSL_IDLE && tick) begin
        prev_dev_ff <= dev_ff;
        dev_ff <= nxt_dev;
      end
    end
  end

  // integrator holds at zero when reset by contact or loop not running
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      integ_ff <= '0;
    end else if (cfg.ireset_pin | ~run_loop) begin
      integ_ff <= '0;
    end else if (state_ff == pidsl_pkg::PIDSL_CALC) begin
      integ_ff <= integ_clip;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pid_ff <= '0;
      pid_out_ff <= 16'h0000;
      filt_step_ff <= 1'b0;
    end else begin
      if (state_ff == pidsl_pkg::PIDSL_INTEG) pid_ff <= pid_sum;
      if (state_ff == pidsl_pkg::PIDSL_FILT) pid_out_ff <= pid_sat;
      filt_step_ff <= (state_ff == pidsl_pkg::PIDSL_FILT);
    end
  end

  pidsl_filter #(
    .W(16)
  ) i_pidsl_filter (
    .clk(clk),
    .rst(rst),
    .step(filt_step_ff),
    .din(pid_out_ff),
    .tc((cfg.lag_tc > 16'h0019) ? 16'h0019 : cfg.lag_tc),
    .dout(filt_out)
  );

  // cancel or inactive mode passes target straight through
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_cmd <= 16'h0000;
      loop_active <= 1'b0;
    end else begin
      freq_cmd <= run_loop ? filt_out : target;
      loop_active <= run_loop;
    end
  end

  assign status_w = {26'h0, cfg.ireset_pin, cfg.cancel_pin, cfg.aux_ref, jog_s, loop_active, cfg.loop_on};
endmodule
`default_nettype wire

// ### bench/pidsl_top_sva.sv
/*
  checker for the pid setpoint loop, watching only the top ports.
  assumes one clock, async active-high reset, single-cycle bus master.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pidsl_consts.svh"
module pidsl_top_sva #(
  parameter int SAMPLE_CYC = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic jog_in,
  input wire logic step1_in,
  input wire logic step2_in,
  input wire logic [3:0] mf_in,
  input wire logic fb_current_sel,
  input wire logic [11:0] voltage_sensor_input,
  input wire logic [11:0] current_sensor_input,
  input wire logic [11:0] aux_input,
  input wire logic [15:0] freq_cmd,
  input wire logic loop_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a read taken at this edge; its data shows with the ack one edge later
  sequence s_read(logic [7:0] a);
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == a;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held past one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request left unanswered");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  reset_quiet_a: assert property ($past(rst) |-> freq_cmd == 16'h0000 && !loop_active)
    else $error("outputs not idle after reset");
  freq_limit_a: assert property (freq_cmd <= `PIDSL_FREQ_MAX) else $error("command above top frequency");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i >= 8'h40
    |=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  out_mirror_a: assert property (s_read(8'h3C) |=> wb_dat_o[15:0] == $past(freq_cmd)) else $error("command readback wrong");
  status_mirror_a: assert property (s_read(8'h38) |=> wb_dat_o[1] == $past(loop_active))
    else $error("status loop bit wrong");
  dat_hold_a: assert property (!wb_cyc_i |=> $stable(wb_dat_o)) else $error("read data moved while idle");
endmodule
bind pidsl_top pidsl_top_sva #(.SAMPLE_CYC(SAMPLE_CYC)) i_pidsl_top_sva (.clk(clk), .rst(rst),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .jog_in(jog_in), .step1_in(step1_in),
  .step2_in(step2_in), .mf_in(mf_in), .fb_current_sel(fb_current_sel), .voltage_sensor_input(voltage_sensor_input),
  .current_sensor_input(current_sensor_input), .aux_input(aux_input), .freq_cmd(freq_cmd),
  .loop_active(loop_active));
`default_nettype wire

// ### bench/pidsl_sensor.sv
/*
  process sensor and contact model: one process level seen by the chosen sensor input.
  assumes the bench sets level, sensor choice and contact requests off the clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pidsl_consts.svh"
module pidsl_sensor (
  input wire logic [11:0] level,
  input wire logic cur_mode,
  input wire logic cancel,
  input wire logic ireset,
  output logic [11:0] volt_word,
  output logic [11:0] cur_word,
  output logic [3:0] contacts
);
  logic [23:0] scaled;
  // 4 ma sits at the live zero; the unused sensor shows an inverted word so stale data cannot pass
  assign scaled = 24'(level) * 24'(`PIDSL_CUR_SPAN) / 24'hFFF;
  assign cur_word = cur_mode ? 12'(`PIDSL_CUR_ZERO + scaled[15:0]) : ~level;
  assign volt_word = cur_mode ? ~level : level;
  // contacts stay open unless the bench asks for cancel or integral reset on purpose
  assign contacts = {2'b00, ireset, cancel};
endmodule
`default_nettype wire

// ### bench/pid_setpoint_loop_test.sv
/*
  self-checking bench for the pid setpoint loop: bus tasks note expected reads, a monitor compares.
  assumes the sensor model in pidsl_sensor and a short sample period.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pidsl_consts.svh"
module pid_setpoint_loop_test;
  localparam int SAMP = 20;
  typedef struct packed {logic [7:0] adr; logic [31:0] val; logic [31:0] msk;} pidsl_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic jog_in = 1'b0;
  logic step1_in = 1'b0;
  logic step2_in = 1'b0;
  logic fb_current_sel = 1'b0;
  logic [11:0] fb_level = 12'h000;
  logic cancel_req = 1'b0;
  logic ireset_req = 1'b0;
  logic [11:0] aux_level = 12'h000;
  logic [3:0] mf_in;
  logic [11:0] volt_w;
  logic [11:0] cur_w;
  logic [15:0] freq_cmd;
  logic loop_active;
  logic [15:0] pre [0:4];
  logic [15:0] defs [0:11] = '{`PIDSL_RST_PRESET1, 16'h0000, 16'h0000, 16'h0000, `PIDSL_RST_JOG, `PIDSL_RST_FBGAIN,
    `PIDSL_RST_PGAIN, `PIDSL_RST_ITIME, 16'h0000, `PIDSL_RST_IUPPER, 16'h0000, 16'h0000};
  pidsl_note_t notes [$];
  pidsl_note_t note;
  int n_fail = 0;
  int compares = 0;
  int seed = 32'hC33EE9DF;

  always #25 clk = ~clk;

  pidsl_top #(.SAMPLE_CYC(SAMP)) i_pidsl_top (.clk(clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .jog_in(jog_in), .step1_in(step1_in), .step2_in(step2_in), .mf_in(mf_in),
    .fb_current_sel(fb_current_sel), .voltage_sensor_input(volt_w), .current_sensor_input(cur_w),
    .aux_input(aux_level), .freq_cmd(freq_cmd), .loop_active(loop_active));
  pidsl_sensor i_pidsl_sensor (.level(fb_level), .cur_mode(fb_current_sel), .cancel(cancel_req),
    .ireset(ireset_req), .volt_word(volt_w), .cur_word(cur_w), .contacts(mf_in));

  task summarize;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one classic cycle; reads leave their expectation for the monitor
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m);
    int n;
    n = 0;
    if (!w) notes.push_back(pidsl_note_t'{adr: a, val: e, msk: m});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      n_fail++;
      $display("MISMATCH ack expected 1 seen %b", wb_ack_o);
      summarize();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 32'h0, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(a, 1'b0, 32'h0, e, m);
  endtask

  // the loop steps once per sample; a few samples cover pin and output latency
  task automatic settle;
    repeat (4 * SAMP) @(posedge clk);
  endtask

  // read data is taken at the ack edge and set against the oldest note
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      compares++;
      if (notes.size() == 0) begin
        n_fail++;
        $display("MISMATCH pending reads expected 1 seen 0");
      end else begin
        note = notes.pop_front();
        if ((wb_dat_o & note.msk) !== note.val) begin
          n_fail++;
          $display("MISMATCH reg %h expected %h seen %h", note.adr, note.val, wb_dat_o & note.msk);
        end
      end
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // setting defaults, then an unmapped place that ignores writes
    for (int i = 0; i < 12; i++) rd(8'(4 * i), 32'(defs[i]), 32'h0000_FFFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    // loop idle with reference digit 1: the command follows the chosen preset
    wr(`PIDSL_ADDR_MODE, 32'h0000_0100);
    for (int i = 0; i < 5; i++) begin
      pre[i] = 16'($unsigned($random(seed)) % 18001);
      wr(8'(4 * i), {16'h0000, pre[i]});
      rd(8'(4 * i), {16'h0000, pre[i]}, 32'h0000_FFFF);
    end
    for (int i = 0; i < 5; i++) begin
      jog_in <= (i == 4);
      step2_in <= i[1];
      step1_in <= i[0];
      settle();
      rd(`PIDSL_ADDR_OUTPUT, {16'h0000, pre[i]}, 32'h0000_FFFF);
    end
    jog_in <= 1'b0;
    // digit 0 swaps preset one for the aux input, driven to full scale
    aux_level <= 12'hFFF;
    wr(`PIDSL_ADDR_MODE, 32'h0000_0000);
    settle();
    rd(`PIDSL_ADDR_OUTPUT, {16'h0000, `PIDSL_FREQ_MAX}, 32'h0000_FFFF);
    // a code one off the pid code leaves the loop idle
    wr(`PIDSL_ADDR_MODE, 32'h0000_0108);
    settle();
    rd(`PIDSL_ADDR_STATUS, 32'h0000_0000, 32'h0000_0002);
    // pid on, full target, feedback at zero: strong gain saturates high
    wr(`PIDSL_ADDR_PRESET4, {16'h0000, `PIDSL_FREQ_MAX});
    wr(`PIDSL_ADDR_PGAIN, 32'h0000_0064);
    wr(`PIDSL_ADDR_MODE, 32'h0000_0109);
    step2_in <= 1'b1;
    step1_in <= 1'b1;
    settle();
    rd(`PIDSL_ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
    rd(`PIDSL_ADDR_OUTPUT, {16'h0000, `PIDSL_FREQ_MAX}, 32'h0000_FFFF);
    // current sensor at 20 ma with zero target drives the command to its floor
    fb_current_sel <= 1'b1;
    fb_level <= 12'hFFF;
    wr(`PIDSL_ADDR_PRESET4, 32'h0000_0000);
    settle();
    rd(`PIDSL_ADDR_OUTPUT, 32'h0000_0000, 32'h0000_FFFF);
    // cancel contact hands the target straight to the command
    wr(`PIDSL_ADDR_MFASSIGN, {24'h000000, `PIDSL_CANCEL_CODE});
    wr(`PIDSL_ADDR_PRESET4, 32'h0000_1234);
    cancel_req <= 1'b1;
    settle();
    rd(`PIDSL_ADDR_OUTPUT, 32'h0000_1234, 32'h0000_FFFF);
    // pure integral on a full deviation climbs to a half-scale bound; short time keeps the wait short
    wr(`PIDSL_ADDR_PGAIN, 32'h0000_0000);
    wr(`PIDSL_ADDR_ITIME, 32'h0000_0001);
    wr(`PIDSL_ADDR_IUPPER, 32'h0000_0032);
    wr(`PIDSL_ADDR_PRESET4, {16'h0000, `PIDSL_FREQ_MAX});
    fb_current_sel <= 1'b0;
    fb_level <= 12'h000;
    cancel_req <= 1'b0;
    repeat (64 * SAMP) @(posedge clk);
    rd(`PIDSL_ADDR_OUTPUT, 32'h0000_2328, 32'h0000_FFFF);
    // integral-reset contact empties the integrator and holds it there
    wr(`PIDSL_ADDR_MFASSIGN, {16'h0000, `PIDSL_IRESET_CODE, `PIDSL_CANCEL_CODE});
    ireset_req <= 1'b1;
    settle();
    rd(`PIDSL_ADDR_OUTPUT, 32'h0000_0000, 32'h0000_FFFF);
    // p only: half detect gain on full feedback leaves half the target as deviation
    wr(`PIDSL_ADDR_ITIME, 32'h0000_0000);
    wr(`PIDSL_ADDR_PGAIN, 32'h0000_000A);
    wr(`PIDSL_ADDR_FBGAIN, 32'h0000_0032);
    fb_level <= 12'hFFF;
    ireset_req <= 1'b0;
    settle();
    rd(`PIDSL_ADDR_OUTPUT, 32'h0000_2328, 32'h0000_FFFF);
    // longest lag: deviation drops to zero but the command only creeps down from half scale
    wr(`PIDSL_ADDR_LAG, 32'h0000_0019);
    wr(`PIDSL_ADDR_FBGAIN, 32'h0000_0064);
    settle();
    rd(`PIDSL_ADDR_OUTPUT, 32'h0000_2300, 32'h0000_FF00);
    summarize();
  end
endmodule
`default_nettype wire
